// File: rtl/lfs_consts.svh
// Constants for the LED driver fault supervisor
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_CLK_MHZ 125
`define LFS_OPEN_MON_US 20000
`define LFS_DIODE_DLY_US 400
`define LFS_OVP_TMO_US 500000
`define LFS_RECHECK_US 10
`define LFS_SHORT_CNT 4
`endif

// File: rtl/lfs_pkg.sv
// Types for the LED driver fault supervisor
package lfs_pkg;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_DIODE_WAIT,
      ST_START,
      ST_RUN,
      ST_LATCH
   } lfs_state_t;
   typedef struct packed {
      logic cur_trip;
      logic cur_trip2x;
      logic out_ov;
      logic out_low;
      logic set_overcur;
      logic over_temp;
      logic temp_release;
      logic input_undervoltage_lockout;
   } lfs_global_t;
endpackage : lfs_pkg

// File: rtl/lfs_supervisor.sv
// Protection and fault supervisor for a six-string boost LED driver
// Overview of operation
// - Switch current trip ends on-time; switch stays off until next period.
// - Feedback low for monitor interval while dimming on: sink off, pull-up on.
// - Pull-up recheck high marks string open, removed from feedback selection.
// - Connected strings keep regulating while an open string is handled.
// - All strings open latches the device off.
// - Feedback above short threshold disables that string only.
// - After delay, low output sense at power-on locks device off.
// - Feedback overvoltage during startup stops switching and latches off.
// - Soft-start reference discharged whenever latched off.
// - Output overvoltage clamps; persisting past timeout latches off.
// - Double current limit every cycle disables boost until it clears.
// - Startup test current; feedback below short level halts startup, fault.
// - Run-time low feedback rechecked with test current; still low stops boost.
// - Set-current overload disables sinks; resumes automatically when normal.
// - Over-temperature shuts down; restarts only at lower release level.
// - Fault pin driven low when normal, released on any protection but the switch current trip.
// - Fault pin released during input undervoltage lockout.
`timescale 1ns/10ps
`include "lfs_consts.svh"
module lfs_supervisor #(
   parameter int NSTR = 6,
   parameter int OPEN_MON_CYC = `LFS_OPEN_MON_US * `LFS_CLK_MHZ,
   parameter int DIODE_DLY_CYC = `LFS_DIODE_DLY_US * `LFS_CLK_MHZ,
   parameter int OVP_TMO_CYC = `LFS_OVP_TMO_US * `LFS_CLK_MHZ,
   parameter int RECHECK_CYC = `LFS_RECHECK_US * `LFS_CLK_MHZ
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic switch_period_start,
   input wire logic switch_on,
   input wire lfs_pkg::lfs_global_t glob_in,
   input wire logic [NSTR-1:0] dim_on,
   input wire logic [NSTR-1:0] fb_low,
   input wire logic [NSTR-1:0] fb_pulled_high,
   input wire logic [NSTR-1:0] fb_short_thr,
   input wire logic [NSTR-1:0] fb_ovp,
   input wire logic [NSTR-1:0] fb_test_low,
   input wire logic soft_start_done,
   output logic gate_allow,
   output logic boost_run,
   output logic out_clamp,
   output logic [NSTR-1:0] sink_en,
   output logic [NSTR-1:0] fb_select,
   output logic [NSTR-1:0] pullup_en,
   output logic [NSTR-1:0] test_src_en,
   output logic ref_discharge,
   output logic latched,
   output logic fault_o,
   output logic fault_oe
);
   initial begin
      if (NSTR < 1 || NSTR > 16) $error("NSTR out of range");
      if (OPEN_MON_CYC < 1 || DIODE_DLY_CYC < 1) $error("bad delay");
      if (OVP_TMO_CYC < 1 || RECHECK_CYC < 1) $error("bad delay");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [7:0] g_s1, g_s2;
   logic [NSTR-1:0] dim_s1, dim_s2, lo_s1, lo_s2, ph_s1, ph_s2;
   logic [NSTR-1:0] sh_s1, sh_s2, ov_s1, ov_s2, tl_s1, tl_s2;
   logic en_s1, en_s2;
   logic per_s1, per_s2;
   logic on_s1, on_s2;
   logic ss_s1, ss_s2;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         g_s1 <= '0;
         g_s2 <= '0;
         dim_s1 <= '0;
         dim_s2 <= '0;
         lo_s1 <= '0;
         lo_s2 <= '0;
         ph_s1 <= '0;
         ph_s2 <= '0;
         sh_s1 <= '0;
         sh_s2 <= '0;
         ov_s1 <= '0;
         ov_s2 <= '0;
         tl_s1 <= '0;
         tl_s2 <= '0;
         en_s1 <= 1'b0;
         en_s2 <= 1'b0;
         per_s1 <= 1'b0;
         per_s2 <= 1'b0;
         on_s1 <= 1'b0;
         on_s2 <= 1'b0;
         ss_s1 <= 1'b0;
         ss_s2 <= 1'b0;
      end else begin
         g_s1 <= glob_in;
         g_s2 <= g_s1;
         dim_s1 <= dim_on;
         dim_s2 <= dim_s1;
         lo_s1 <= fb_low;
         lo_s2 <= lo_s1;
         ph_s1 <= fb_pulled_high;
         ph_s2 <= ph_s1;
         sh_s1 <= fb_short_thr;
         sh_s2 <= sh_s1;
         ov_s1 <= fb_ovp;
         ov_s2 <= ov_s1;
         tl_s1 <= fb_test_low;
         tl_s2 <= tl_s1;
         en_s1 <= enable;
         en_s2 <= en_s1;
         per_s1 <= switch_period_start;
         per_s2 <= per_s1;
         on_s1 <= switch_on;
         on_s2 <= on_s1;
         ss_s1 <= soft_start_done;
         ss_s2 <= ss_s1;
      end
   end
   lfs_pkg::lfs_global_t g;
   assign g = lfs_pkg::lfs_global_t'(g_s2);
   wire en_s = en_s2;
   wire per_s = per_s2;
   wire on_s = on_s2;
   wire ss_done = ss_s2;

   ////////////////////////////////////////////////////////////////////////////
   // Count end helpers
   function automatic logic mon_end(input logic [31:0] c);
      return c == 32'(OPEN_MON_CYC - 1);
   endfunction : mon_end
   function automatic logic chk_end(input logic [31:0] c);
      return c == 32'(RECHECK_CYC - 1);
   endfunction : chk_end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   lfs_pkg::lfs_state_t state, next_state;
   logic en_d;
   logic [31:0] dcnt;
   logic [31:0] ovcnt;
   logic [NSTR-1:0] open_flag, short_flag;
   logic any_short_gnd;
   logic boost_ok;
   logic sinks_ok;
   logic active;
   logic run_state;
   wire en_rise = en_s & ~en_d;
   wire all_open = &open_flag;
   wire startup = (state == lfs_pkg::ST_START);
   wire diode_done = (state == lfs_pkg::ST_DIODE_WAIT) &&
      (dcnt == 32'(DIODE_DLY_CYC - 1));
   wire start_fail = startup && |(tl_s2 & ~open_flag);
   wire ovp_tmo = ovcnt == 32'(OVP_TMO_CYC - 1);
   wire latch_cause = all_open
      || (startup && |ov_s2)
      || ovp_tmo
      || any_short_gnd
      || start_fail;

   always_comb begin
      next_state = state;
      case (state)
         lfs_pkg::ST_OFF: begin
            if (en_s && !g.input_undervoltage_lockout) next_state = lfs_pkg::ST_DIODE_WAIT;
         end
         lfs_pkg::ST_DIODE_WAIT: begin
            if (diode_done) begin
               if (g.out_low) next_state = lfs_pkg::ST_LATCH;
               else next_state = lfs_pkg::ST_START;
            end
         end
         lfs_pkg::ST_START: begin
            if (latch_cause) next_state = lfs_pkg::ST_LATCH;
            else if (ss_done) next_state = lfs_pkg::ST_RUN;
         end
         lfs_pkg::ST_RUN: begin
            if (latch_cause) next_state = lfs_pkg::ST_LATCH;
         end
         default: begin
            next_state = lfs_pkg::ST_LATCH;
         end
      endcase
      if (!en_s) next_state = lfs_pkg::ST_OFF;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= lfs_pkg::ST_OFF;
         en_d <= 1'b0;
      end else begin
         state <= next_state;
         en_d <= en_s;
      end
   end

   // Diode check delay counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dcnt <= '0;
      end else begin
         if (state == lfs_pkg::ST_DIODE_WAIT) dcnt <= dcnt + 32'h1;
         else dcnt <= '0;
      end
   end

   // Output overvoltage timeout counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ovcnt <= '0;
      end else begin
         if (!g.out_ov || !active) ovcnt <= '0;
         else if (boost_ok && !ovp_tmo) ovcnt <= ovcnt + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-string open, short and short-to-ground supervision
   logic [NSTR-1:0] sg_hit;
   assign run_state = (state == lfs_pkg::ST_RUN);
   assign active = startup || run_state;
   genvar i;
   generate
      for (i = 0; i < NSTR; i++) begin : g_str
         typedef enum logic [1:0] {S_MON, S_PULL, S_REOFF, S_RETEST} s_t;
         s_t ss;
         logic [31:0] cnt;
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               ss <= S_MON;
               cnt <= '0;
               open_flag[i] <= 1'b0;
               short_flag[i] <= 1'b0;
               sg_hit[i] <= 1'b0;
            end else if (en_rise || !active) begin
               ss <= S_MON;
               cnt <= '0;
               if (en_rise) begin
                  open_flag[i] <= 1'b0;
                  short_flag[i] <= 1'b0;
                  sg_hit[i] <= 1'b0;
               end
            end else if (!open_flag[i] && !short_flag[i]) begin
               if (sh_s2[i]) short_flag[i] <= 1'b1;
               case (ss)
                  S_MON: begin
                     if (dim_s2[i] && lo_s2[i]) begin
                        if (mon_end(cnt)) begin
                           ss <= S_PULL;
                           cnt <= '0;
                        end else cnt <= cnt + 32'h1;
                     end else if (dim_s2[i] && tl_s2[i] &&
                        state == lfs_pkg::ST_RUN) begin
                        ss <= S_REOFF;
                        cnt <= '0;
                     end else cnt <= '0;
                  end
                  S_PULL: begin
                     if (chk_end(cnt)) begin
                        if (ph_s2[i]) begin
                           open_flag[i] <= 1'b1;
                           ss <= S_MON;
                        end else if (tl_s2[i] && run_state) begin
                           ss <= S_RETEST;
                        end else begin
                           ss <= S_MON;
                        end
                        cnt <= '0;
                     end else cnt <= cnt + 32'h1;
                  end
                  S_REOFF: begin
                     if (chk_end(cnt)) begin
                        ss <= tl_s2[i] ? S_RETEST : S_MON;
                        cnt <= '0;
                     end else cnt <= cnt + 32'h1;
                  end
                  default: begin
                     if (chk_end(cnt)) begin
                        if (tl_s2[i]) sg_hit[i] <= 1'b1;
                        ss <= S_MON;
                        cnt <= '0;
                     end else cnt <= cnt + 32'h1;
                  end
               endcase
            end
         end
         wire checking = (ss != S_MON);
         // Other strings keep their sinks during another's check
         assign sink_en[i] = sinks_ok && dim_s2[i] && !checking &&
            !open_flag[i] && !short_flag[i];
         assign fb_select[i] = !open_flag[i] && !short_flag[i] &&
            !checking;
         assign pullup_en[i] = active && (ss == S_PULL);
         assign test_src_en[i] = startup || (active && ss == S_RETEST);
      end
   endgenerate
   assign any_short_gnd = |sg_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Temperature hysteresis and switch control
   logic hot;
   logic cyc_trip, period_blk, trip2x_all;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hot <= 1'b0;
      end else begin
         if (g.over_temp) hot <= 1'b1;
         else if (g.temp_release) hot <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         period_blk <= 1'b0;
      end else begin
         if (per_s) period_blk <= 1'b0;
         else if (on_s && g.cur_trip) period_blk <= 1'b1;
      end
   end

   // 2x limit seen in every period holds boost off
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cyc_trip <= 1'b0;
         trip2x_all <= 1'b0;
      end else begin
         if (per_s) begin
            trip2x_all <= cyc_trip;
            cyc_trip <= 1'b0;
         end else if (g.cur_trip2x) cyc_trip <= 1'b1;
      end
   end

   assign boost_ok = active && !hot && !g.input_undervoltage_lockout && !trip2x_all;
   assign sinks_ok = active && !hot && !g.input_undervoltage_lockout && !g.set_overcur;
   assign gate_allow = boost_ok && !period_blk && !g.cur_trip;
   assign boost_run = boost_ok && !start_fail;
   assign out_clamp = boost_ok && g.out_ov;
   assign latched = (state == lfs_pkg::ST_LATCH);
   assign ref_discharge = latched || !active;

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain fault indicator
   // Latching, global and per-string causes
   wire latch_fault = latched || start_fail;
   wire global_fault = hot || g.set_overcur || g.out_ov || trip2x_all;
   wire string_fault = |open_flag || |short_flag;
   wire any_fault = latch_fault || global_fault || string_fault;
   assign fault_o = 1'b0;
   assign fault_oe = en_s && !any_fault && !g.input_undervoltage_lockout;
endmodule : lfs_supervisor

// File: dv/lfs_supervisor_checker.sv
// Assertion checker for the LED driver fault supervisor
`timescale 1ns/10ps
module lfs_supervisor_checker #(
   parameter int NSTR = 6
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic switch_on,
   input wire lfs_pkg::lfs_global_t glob_in,
   input wire logic [NSTR-1:0] fb_short_thr,
   input wire logic [NSTR-1:0] fb_ovp,
   input wire logic gate_allow,
   input wire logic boost_run,
   input wire logic out_clamp,
   input wire logic [NSTR-1:0] sink_en,
   input wire logic [NSTR-1:0] fb_select,
   input wire logic [NSTR-1:0] pullup_en,
   input wire logic [NSTR-1:0] test_src_en,
   input wire logic ref_discharge,
   input wire logic latched,
   input wire logic fault_o,
   input wire logic fault_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   AST_CUR_TRIP: assert property ((glob_in.cur_trip && switch_on)[*3]
      |-> !gate_allow) else $error("gate allowed after trip");
   AST_SHORT_OFF: assert property (fb_short_thr[0][*8]
      |-> !sink_en[0] && !fb_select[0]) else $error("short string on");
   AST_FB_OVP: assert property ((|fb_ovp && &test_src_en)[*3]
      |-> ##[0:3] latched) else $error("no latch on feedback ovp");
   AST_LATCH_REF: assert property (latched |-> ref_discharge)
      else $error("reference not discharged");
   AST_CLAMP: assert property (glob_in.out_ov[*3] ##0 boost_run
      |-> out_clamp) else $error("no output clamp");
   AST_SET_OC: assert property (glob_in.set_overcur[*3]
      |-> sink_en == '0) else $error("sinks on at set overcurrent");
   AST_TEMP: assert property (glob_in.over_temp[*4]
      |-> !boost_run) else $error("boost on at over temperature");
   AST_FAULT_LATCH: assert property (latched |-> !fault_oe && !fault_o)
      else $error("fault pin low while latched");
   AST_INPUT_UNDERVOLTAGE_LOCKOUT: assert property (glob_in.input_undervoltage_lockout[*3] |-> !fault_oe)
      else $error("fault pin low in lockout");
   AST_LATCH_HOLD: assert property (latched && enable && $past(enable)
      |=> latched) else $error("latch lost while enabled");
   COV_LATCH: cover property ($rose(latched));
   COV_PULLUP: cover property (pullup_en != '0);
   COV_START: cover property (&test_src_en);
endmodule : lfs_supervisor_checker
////////////////////////////////////////////////////////////////////////////////
bind lfs_supervisor lfs_supervisor_checker #(.NSTR(NSTR)) chk_u (
   .core_clk, .rst, .enable, .switch_on, .glob_in, .fb_short_thr, .fb_ovp,
   .gate_allow, .boost_run, .out_clamp, .sink_en, .fb_select, .pullup_en,
   .test_src_en, .ref_discharge, .latched, .fault_o, .fault_oe);

// File: dv/lfs_string_model.sv
// Comparator view of six LED strings with injectable faults
`timescale 1ns/10ps
module lfs_string_model (
   input wire logic [5:0] sink_en,
   input wire logic [5:0] pullup_en,
   input wire logic [5:0] open_m,
   input wire logic [5:0] gnd_m,
   input wire logic [5:0] short_m,
   input wire logic [5:0] ovp_m,
   output logic [5:0] fb_low,
   output logic [5:0] fb_pulled_high,
   output logic [5:0] fb_short_thr,
   output logic [5:0] fb_ovp,
   output logic [5:0] fb_test_low
);
   // Open string drops to zero while sinking, rises on pull-up
   assign fb_low = (open_m & sink_en) | gnd_m;
   assign fb_pulled_high = open_m & pullup_en;
   assign fb_short_thr = short_m;
   assign fb_ovp = ovp_m;
   // Grounded pin stays low even with test current
   assign fb_test_low = gnd_m;
endmodule : lfs_string_model

// File: dv/test_lfs_supervisor.sv
// Self-checking bench for the LED driver fault supervisor
`timescale 1ns/10ps
module test_lfs_supervisor;
   localparam int MON = 20, DLY = 10, TMO = 30, RCK = 3;
   logic core_clk = 0, rst = 1, enable = 0, sps = 0, sw_on = 0, ssd = 0;
   lfs_pkg::lfs_global_t g = '0;
   logic [5:0] dim_on = '0, open_m = '0, gnd_m = '0, short_m = '0, ovp_m = '0;
   logic [5:0] fb_low, fb_ph, fb_st, fb_ovp, fb_tl, sink_en, fb_select;
   logic [5:0] pullup_en, test_src_en;
   logic gate_allow, boost_run, out_clamp, ref_discharge, latched;
   logic fault_o, fault_oe;
   logic [15:0] lf = 16'h0009;
   int err_total = 0, samples_checked = 0;
   lfs_supervisor #(.OPEN_MON_CYC(MON), .DIODE_DLY_CYC(DLY),
      .OVP_TMO_CYC(TMO), .RECHECK_CYC(RCK)) dut_u (
      .core_clk(core_clk), .rst(rst), .enable(enable),
      .switch_period_start(sps), .switch_on(sw_on), .glob_in(g),
      .dim_on(dim_on), .fb_low(fb_low), .fb_pulled_high(fb_ph),
      .fb_short_thr(fb_st), .fb_ovp(fb_ovp), .fb_test_low(fb_tl),
      .soft_start_done(ssd), .gate_allow(gate_allow), .boost_run(boost_run),
      .out_clamp(out_clamp), .sink_en(sink_en), .fb_select(fb_select),
      .pullup_en(pullup_en), .test_src_en(test_src_en),
      .ref_discharge(ref_discharge), .latched(latched), .fault_o(fault_o),
      .fault_oe(fault_oe));
   lfs_string_model str_u (.sink_en(sink_en), .pullup_en(pullup_en),
      .open_m(open_m), .gnd_m(gnd_m), .short_m(short_m), .ovp_m(ovp_m),
      .fb_low(fb_low), .fb_pulled_high(fb_ph), .fb_short_thr(fb_st),
      .fb_ovp(fb_ovp), .fb_test_low(fb_tl));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [7:0] fsel(input logic [5:0] gone);
      return {2'b00, ~gone};
   endfunction : fsel
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("checked=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic power;
      int i;
      enable = 1;
      for (i = 0; i < DLY + 20 && test_src_en !== 6'h3f; i++) tick(1);
      if (i == DLY + 20) begin
         err_total++;
         conclude();
      end
   endtask : power
   task automatic pulse;
      sps = 1;
      tick(1);
      sps = 0;
      tick(3);
   endtask : pulse
   task automatic off;
      enable = 0;
      g = '0;
      {ssd, open_m, gnd_m, short_m, ovp_m} = '0;
      tick(6);
   endtask : off
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(5);
      rst = 0;
      g.out_low = 1;
      enable = 1;
      tick(DLY + 8);
      chk(latched, 8'h01);
      chk(ref_discharge, 8'h01);
      chk(fault_oe, 8'h00);
      off();
      chk(latched, 8'h00);
      gnd_m = 6'h04;
      power();
      tick(8);
      chk(latched, 8'h01);
      off();
      dim_on = 6'h3f;
      power();
      chk(test_src_en, 8'h3f);
      ssd = 1;
      tick(6);
      chk(fault_oe, 8'h01);
      chk(fb_select, fsel(6'h00));
      open_m = 6'h02;
      tick(MON + RCK + 10);
      chk(fb_select, fsel(open_m));
      chk(sink_en & open_m, 8'h00);
      chk(latched, 8'h00);
      open_m = 6'h3f;
      tick(2 * (MON + RCK + 10));
      chk(latched, 8'h01);
      off();
      power();
      ssd = 1;
      sw_on = 1;
      tick(6);
      g.cur_trip = 1;
      tick(3);
      chk(gate_allow, 8'h00);
      g.cur_trip = 0;
      tick(3);
      chk(gate_allow, 8'h00);
      sps = 1;
      tick(1);
      sps = 0;
      tick(3);
      chk(gate_allow, 8'h01);
      g.over_temp = 1;
      tick(4);
      chk(boost_run, 8'h00);
      g.over_temp = 0;
      tick(4);
      chk(boost_run, 8'h00);
      g.temp_release = 1;
      tick(4);
      chk(boost_run, 8'h01);
      g.temp_release = 0;
      short_m = 6'h01;
      tick(12);
      chk(fb_select, fsel(short_m));
      chk(sink_en, 8'h3e);
      g.set_overcur = 1;
      tick(4);
      chk(sink_en, 8'h00);
      g.set_overcur = 0;
      tick(4);
      chk(sink_en, 8'h3e);
      repeat (40) begin
         lf = lfsr(lf);
         {sw_on, sps, g.cur_trip, g.set_overcur} = lf[3:0];
         g.out_ov = lf[4] & lf[5];
         g.input_undervoltage_lockout = lf[6] & lf[7] & lf[8];
         tick(4);
         chk(sink_en, (g.set_overcur | g.input_undervoltage_lockout) ? 8'h00 : fsel(short_m));
      end
      g = '0;
      sps = 0;
      tick(4);
      g.cur_trip2x = 1;
      tick(2);
      pulse();
      pulse();
      chk(boost_run, 8'h00);
      g.cur_trip2x = 0;
      pulse();
      pulse();
      chk(boost_run, 8'h01);
      g.out_ov = 1;
      tick(4);
      chk(out_clamp, 8'h01);
      tick(TMO + 6);
      chk(latched, 8'h01);
      off();
      power();
      ovp_m = 6'h01;
      tick(4);
      chk(latched, 8'h01);
      off();
      power();
      ssd = 1;
      tick(6);
      gnd_m = 6'h08;
      tick(MON + 2 * RCK + 12);
      chk(latched, 8'h01);
      chk(boost_run, 8'h00);
      conclude();
   end
endmodule : test_lfs_supervisor
